// ==== inc/ptc_pkg.sv ====
package ptc_pkg;

  // management frame layout
  localparam logic [5:0] PTC_PREAMBLE_LEN = 6'h20;
  localparam logic [1:0] PTC_OP_READ      = 2'h2;
  localparam logic [1:0] PTC_OP_WRITE     = 2'h1;
  localparam logic [4:0] PTC_FIELD_LAST   = 5'h04;
  localparam logic [4:0] PTC_DATA_LAST    = 5'h0F;

  // register offsets
  localparam logic [4:0] PTC_REG_SPECIAL_CONTROL = 5'h11;
  localparam logic [4:0] PTC_REG_PHY_ADDRESS     = 5'h12;
  localparam logic [4:0] PTC_REG_FALSE_CARRIER   = 5'h13;
  localparam logic [4:0] PTC_REG_DISCONNECT      = 5'h14;
  localparam logic [4:0] PTC_REG_ERROR_FRAME     = 5'h15;
  localparam logic [4:0] PTC_REG_SYMBOL_ERROR    = 5'h16;
  localparam logic [4:0] PTC_REG_PREMATURE_END   = 5'h17;
  localparam logic [4:0] PTC_REG_SLOW_EOF_ERROR  = 5'h18;
  localparam logic [4:0] PTC_REG_JABBER_DETECT   = 5'h19;
  localparam logic [4:0] PTC_REG_EQUALIZER       = 5'h1A;

  // reset values
  localparam logic [15:0] PTC_SPECIAL_CONTROL_RST = 16'h0000;
  localparam logic [15:0] PTC_EQUALIZER_RST       = 16'h0000;
  localparam logic [4:0]  PTC_PHY_ADDR_VALUE      = 5'h01;

  // special control field positions
  localparam int PTC_B_SCRAMBLER_BYPASS = 15;
  localparam int PTC_B_CODER_BYPASS     = 14;
  localparam int PTC_B_FORCE_H          = 13;
  localparam int PTC_B_FORCE_34         = 12;
  localparam int PTC_B_GOOD_LINK        = 11;
  localparam int PTC_B_TX_CRS_DISABLE   = 9;
  localparam int PTC_B_DYN_PD_DISABLE   = 8;
  localparam int PTC_B_AN_LOOPBACK      = 7;
  localparam int PTC_B_TRISTATE         = 6;
  localparam int PTC_B_FILTER_BYPASS    = 5;
  localparam int PTC_B_POLARITY_DISABLE = 4;
  localparam int PTC_B_SQUELCH_DISABLE  = 3;
  localparam int PTC_B_EXT_SQUELCH      = 2;
  localparam int PTC_B_LINK_DISABLE     = 1;
  localparam int PTC_B_JABBER_DISABLE   = 0;

  // event counters, index = offset - first counter offset
  localparam int         PTC_CNT_NUM   = 7;
  localparam int         PTC_CNT_WIDTH = 16;
  localparam logic [2:0] PTC_SYM_RUN   = 3'h6;

  typedef enum logic [2:0] {
    PTC_IDLE,
    PTC_START,
    PTC_OPCODE,
    PTC_PHYAD,
    PTC_REGAD,
    PTC_TURN,
    PTC_DATA
  } ptc_state_t;

endpackage

// ==== inc/ptc_cnt_if.sv ====
interface ptc_cnt_if #(parameter int W = 16);
  logic         inc;
  logic         clr;
  logic [W-1:0] value;

  modport ctl (output inc, output clr, input value);
  modport cnt (input inc, input clr, output value);
endinterface

// ==== core/ptc_sat_counter.sv ====
module ptc_sat_counter
  import ptc_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  ptc_cnt_if.cnt   port
);

  typedef struct packed {
    logic [W-1:0] value;
  } ptc_cnt_state_t;

  ptc_cnt_state_t r;
  ptc_cnt_state_t next_r;

  always_comb begin
    next_r = r;
    if (port.clr) begin
      // an event coinciding with the clearing read is kept as one
      next_r.value = port.inc ? W'(1) : '0; // [RQ23]
    end else if (port.inc && (r.value != {W{1'b1}})) begin
      next_r.value = r.value + W'(1); // [RQ17]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0; // [RQ23]
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign port.value = r.value;

endmodule

// ==== core/ptc_regs.sv ====
// What this block does
// [RQ1] control bit 15 routes symbols around scrambler and descrambler; resets zero
// [RQ2] control bit 14 bypasses the 4B/5B block coder; resets zero
// [RQ3] bit 13 forces H test pattern, bit 12 forces 34 pattern
// [RQ4] control bit 11 forces the 100BASE-TX link good
// [RQ5] control bit 9 suppresses carrier sense from own transmission
// [RQ6] control bit 8 forbids dynamic power-down
// [RQ7] control bit 7 runs auto-negotiation in loopback mode
// [RQ8] control bit 6 puts the line transmit driver in high impedance
// [RQ9] control bit 5 bypasses the receive filter
// [RQ10] control bit 4 disables automatic polarity correction
// [RQ11] control bit 3 skips the 10BASE-T squelch test
// [RQ12] control bit 2 enables 10BASE-T extended squelch
// [RQ13] control bit 1 disables link integrity and holds link down
// [RQ14] control bit 0 disables jabber; all control bits reset to zero
// [RQ15] address register reads 00001b in low bits, zero above; writes ignored
// [RQ16] 16-bit false carrier count, cleared by a read
// [RQ17] 16-bit disconnect count, saturates, cleared by a read
// [RQ18] error frame count rises at most once per errored frame
// [RQ19] symbol error count; each run of up to six bad symbols adds one
// [RQ20] premature end count, saturating, cleared by a read
// [RQ21] 10BASE-T end-of-frame error count, saturating, cleared by a read
// [RQ22] jabber detect count, saturating, cleared by a read
// [RQ23] counters start at zero; increment during clearing read leaves one
module ptc_regs
  import ptc_pkg::*;
#(
  parameter logic [4:0] PHY_ADDR = PTC_PHY_ADDR_VALUE,
  parameter int         CW       = PTC_CNT_WIDTH
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic mdc,
  input  wire logic mdio_in,
  output logic      mdio_out,
  output logic      mdio_drive_n,
  input  wire logic false_carrier_evt,
  input  wire logic disconnect_evt,
  input  wire logic premature_end_evt,
  input  wire logic slow_eof_err_evt,
  input  wire logic jabber_evt,
  input  wire logic rx_frame_active,
  input  wire logic rx_symbol_valid,
  input  wire logic rx_symbol_bad,
  output logic      scrambler_bypass,
  output logic      coder_bypass,
  output logic      force_h_pattern,
  output logic      force_34_pattern,
  output logic      force_link_good,
  output logic      tx_crs_disable,
  output logic      dyn_powerdown_disable,
  output logic      an_loopback,
  output logic      line_driver_tristate,
  output logic      rx_filter_bypass,
  output logic      auto_polarity_disable,
  output logic      squelch_test_disable,
  output logic      extended_squelch,
  output logic      link_integrity_disable,
  output logic      jabber_disable
);

  typedef struct packed {
    ptc_state_t  state;
    logic        mdc_q;
    logic [5:0]  ones;
    logic [4:0]  bitn;
    logic [15:0] shreg;
    logic [1:0]  op;
    logic [4:0]  regad;
    logic        sel;
    logic        talk;
    logic [15:0] ctrl;
    logic [15:0] eq;
    logic        mdio_out;
    logic        mdio_drive_n;
    logic [2:0]  sym_run;
    logic        frame_err_seen;
  } ptc_main_t;

  ptc_main_t r;
  ptc_main_t next_r;

  logic [PTC_CNT_NUM-1:0] cnt_inc;
  logic [PTC_CNT_NUM-1:0] cnt_clr;
  logic [CW-1:0]          cnt_val [PTC_CNT_NUM];

  logic       rise;
  logic [4:0] field_n;
  logic       inc_sym;
  logic       inc_frame;
  logic       err_now;

  // the readback mux; unmapped offsets leave the line released
  function automatic logic [16:0] read_value(input logic [4:0] ad,
                                             input logic [15:0] ctrl,
                                             input logic [15:0] eq);
    logic [2:0] idx;
    idx = 3'(ad - PTC_REG_FALSE_CARRIER);
    case (ad)
      PTC_REG_SPECIAL_CONTROL: read_value = {1'b1, ctrl};
      PTC_REG_PHY_ADDRESS:     read_value = {1'b1, 11'h000, PHY_ADDR}; // [RQ15]
      PTC_REG_FALSE_CARRIER,
      PTC_REG_DISCONNECT,
      PTC_REG_ERROR_FRAME,
      PTC_REG_SYMBOL_ERROR,
      PTC_REG_PREMATURE_END,
      PTC_REG_SLOW_EOF_ERROR,
      PTC_REG_JABBER_DETECT:   read_value = {1'b1, 16'(cnt_val[idx])};
      PTC_REG_EQUALIZER:       read_value = {1'b1, eq};
      default:                 read_value = 17'h00000;
    endcase
  endfunction

  always_comb begin
    logic [16:0] rv;
    logic [15:0] wdata;
    rv        = 17'h00000;
    wdata     = {r.shreg[14:0], mdio_in};
    next_r    = r;
    cnt_clr   = '0;
    inc_sym   = 1'b0;
    inc_frame = 1'b0;
    rise      = mdc && !r.mdc_q;
    field_n   = {r.shreg[3:0], mdio_in};
    next_r.mdc_q = mdc;

    // receive error tracking, per symbol and per frame
    err_now = (rx_frame_active && rx_symbol_valid && rx_symbol_bad)
              || premature_end_evt;
    if (!rx_frame_active) begin
      next_r.sym_run = 3'h0;
    end else if (rx_symbol_valid) begin
      if (rx_symbol_bad) begin
        inc_sym = (r.sym_run == 3'h0); // [RQ19]
        next_r.sym_run = (r.sym_run == PTC_SYM_RUN - 3'h1) ? 3'h0
                         : r.sym_run + 3'h1; // [RQ19]
      end else begin
        next_r.sym_run = 3'h0;
      end
    end
    inc_frame = err_now && !r.frame_err_seen; // [RQ18]
    next_r.frame_err_seen = rx_frame_active
                            && (r.frame_err_seen || err_now); // [RQ18]

    if (rise) begin
      next_r.shreg = {r.shreg[14:0], mdio_in};
      case (r.state)
        PTC_IDLE: begin
          if (mdio_in) begin
            if (r.ones != PTC_PREAMBLE_LEN) begin
              next_r.ones = r.ones + 6'h01;
            end
          end else begin
            // a zero ends the preamble; too short a preamble is dropped
            if (r.ones == PTC_PREAMBLE_LEN) begin
              next_r.state = PTC_START;
            end
            next_r.ones = 6'h00;
          end
        end
        PTC_START: begin
          next_r.bitn  = 5'h00;
          next_r.state = mdio_in ? PTC_OPCODE : PTC_IDLE;
        end
        PTC_OPCODE: begin
          next_r.op   = {r.op[0], mdio_in};
          next_r.bitn = r.bitn + 5'h01;
          if (r.bitn != 5'h00) begin
            next_r.bitn  = 5'h00;
            next_r.state = PTC_PHYAD;
          end
        end
        PTC_PHYAD: begin
          next_r.bitn = r.bitn + 5'h01;
          if (r.bitn == PTC_FIELD_LAST) begin
            next_r.bitn  = 5'h00;
            next_r.sel   = (field_n == PHY_ADDR);
            next_r.state = PTC_REGAD;
          end
        end
        PTC_REGAD: begin
          next_r.bitn = r.bitn + 5'h01;
          if (r.bitn == PTC_FIELD_LAST) begin
            next_r.bitn  = 5'h00;
            next_r.regad = field_n;
            next_r.state = PTC_TURN;
            rv = read_value(field_n, r.ctrl, r.eq);
            next_r.talk  = r.sel && (r.op == PTC_OP_READ) && rv[16];
            next_r.shreg = rv[15:0];
            // reading a counter clears it in the same frame
            for (int i = 0; i < PTC_CNT_NUM; i++) begin
              cnt_clr[i] = r.sel && (r.op == PTC_OP_READ)
                           && (field_n == PTC_REG_FALSE_CARRIER + 5'(i)); // [RQ16]
            end
          end
        end
        PTC_TURN: begin
          next_r.shreg = r.shreg;
          next_r.bitn  = r.bitn + 5'h01;
          if (r.bitn == 5'h00) begin
            if (r.talk) begin
              next_r.mdio_drive_n = 1'b0;
              next_r.mdio_out     = 1'b0;
            end
          end else begin
            next_r.bitn  = 5'h00;
            next_r.state = PTC_DATA;
            if (r.talk) begin
              next_r.mdio_out = r.shreg[15];
              next_r.shreg    = {r.shreg[14:0], 1'b0};
            end
          end
        end
        PTC_DATA: begin
          next_r.bitn = r.bitn + 5'h01;
          if (r.talk) begin
            next_r.mdio_out = r.shreg[15];
            next_r.shreg    = {r.shreg[14:0], 1'b0};
          end
          if (r.bitn == PTC_DATA_LAST) begin
            next_r.state        = PTC_IDLE;
            next_r.bitn         = 5'h00;
            next_r.talk         = 1'b0;
            next_r.mdio_drive_n = 1'b1;
            next_r.mdio_out     = 1'b0;
            if (r.sel && (r.op == PTC_OP_WRITE)) begin
              // address register and counters ignore writes
              if (r.regad == PTC_REG_SPECIAL_CONTROL) begin
                next_r.ctrl = wdata;
              end
              if (r.regad == PTC_REG_EQUALIZER) begin
                next_r.eq = wdata;
              end
            end
          end
        end
        default: begin
          next_r.state = PTC_IDLE;
        end
      endcase
    end
  end

  // counter order follows the register offsets
  assign cnt_inc = {jabber_evt,        // [RQ22]
                    slow_eof_err_evt,  // [RQ21]
                    premature_end_evt, // [RQ20]
                    inc_sym,           // [RQ19]
                    inc_frame,         // [RQ18]
                    disconnect_evt,    // [RQ17]
                    false_carrier_evt}; // [RQ16]

  always_ff @(posedge clk) begin
    if (rst) begin
      r              <= '0;
      r.state        <= PTC_IDLE;
      r.ctrl         <= PTC_SPECIAL_CONTROL_RST; // [RQ14]
      r.eq           <= PTC_EQUALIZER_RST;
      r.mdio_drive_n <= 1'b1;
    end else if (ce) begin
      r <= next_r;
    end
  end

  generate
    for (genvar i = 0; i < PTC_CNT_NUM; i++) begin : g_cnt
      ptc_cnt_if #(.W(CW)) cif ();
      assign cif.inc    = cnt_inc[i];
      assign cif.clr    = cnt_clr[i];
      assign cnt_val[i] = cif.value;
      ptc_sat_counter #(.W(CW)) u_cnt (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .port (cif.cnt)
      );
    end
  endgenerate

  assign mdio_out               = r.mdio_out;
  assign mdio_drive_n           = r.mdio_drive_n;
  assign scrambler_bypass       = r.ctrl[PTC_B_SCRAMBLER_BYPASS]; // [RQ1]
  assign coder_bypass           = r.ctrl[PTC_B_CODER_BYPASS];     // [RQ2]
  assign force_h_pattern        = r.ctrl[PTC_B_FORCE_H];          // [RQ3]
  assign force_34_pattern       = r.ctrl[PTC_B_FORCE_34];         // [RQ3]
  assign force_link_good        = r.ctrl[PTC_B_GOOD_LINK];        // [RQ4]
  assign tx_crs_disable         = r.ctrl[PTC_B_TX_CRS_DISABLE];   // [RQ5]
  assign dyn_powerdown_disable  = r.ctrl[PTC_B_DYN_PD_DISABLE];   // [RQ6]
  assign an_loopback            = r.ctrl[PTC_B_AN_LOOPBACK];      // [RQ7]
  assign line_driver_tristate   = r.ctrl[PTC_B_TRISTATE];         // [RQ8]
  assign rx_filter_bypass       = r.ctrl[PTC_B_FILTER_BYPASS];    // [RQ9]
  assign auto_polarity_disable  = r.ctrl[PTC_B_POLARITY_DISABLE]; // [RQ10]
  assign squelch_test_disable   = r.ctrl[PTC_B_SQUELCH_DISABLE];  // [RQ11]
  assign extended_squelch       = r.ctrl[PTC_B_EXT_SQUELCH];      // [RQ12]
  assign link_integrity_disable = r.ctrl[PTC_B_LINK_DISABLE];     // [RQ13]
  assign jabber_disable         = r.ctrl[PTC_B_JABBER_DISABLE];   // [RQ14]

endmodule

// ==== test/ptc_regs_props.sv ====
module ptc_regs_props (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic mdc,
  input wire logic mdio_out,
  input wire logic mdio_drive_n,
  input wire logic scrambler_bypass,
  input wire logic line_driver_tristate,
  input wire logic jabber_disable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [2:0] ctl;
  assign ctl = {scrambler_bypass, line_driver_tristate, jabber_disable};
  // each of the three checked control bits and every line change must follow a detected mdc rise
  sequence s_rise;
    $past(mdc) && !$past(mdc, 2);
  endsequence
  property p_rst_clear;
    @(posedge clk) disable iff (1'b0)
    rst |=> ctl == 3'h0 && mdio_drive_n && !mdio_out;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("outputs not cleared by reset");
  property p_ctl_at_rise;
    $changed(ctl) |-> s_rise;
  endproperty
  a_ctl_at_rise: assert property (p_ctl_at_rise)
    else $error("control bit changed without a frame bit");
  property p_drv_at_rise;
    $fell(mdio_drive_n) |-> s_rise;
  endproperty
  a_drv_at_rise: assert property (p_drv_at_rise)
    else $error("line driven off a frame bit");
  property p_drv_zero;
    $fell(mdio_drive_n) |-> (!mdio_drive_n && !mdio_out) [*4];
  endproperty
  a_drv_zero: assert property (p_drv_zero)
    else $error("turnaround not driven low");
  property p_drv_hold;
    $fell(mdio_drive_n) |-> !mdio_drive_n [*8];
  endproperty
  a_drv_hold: assert property (p_drv_hold)
    else $error("read data window cut short");
  property p_out_at_rise;
    $changed(mdio_out) |-> s_rise;
  endproperty
  a_out_at_rise: assert property (p_out_at_rise)
    else $error("data bit changed between frame bits");
  property p_rel_at_rise;
    $rose(mdio_drive_n) |-> s_rise;
  endproperty
  a_rel_at_rise: assert property (p_rel_at_rise)
    else $error("line released off a frame bit");
  property p_ce_freeze;
    !ce |=> $stable(ctl) && $stable(mdio_drive_n) && $stable(mdio_out);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("state moved with clock enable low");
  c_read: cover property ($fell(mdio_drive_n));
  c_write: cover property ($rose(scrambler_bypass));
  c_jab: cover property ($rose(jabber_disable));
endmodule

// ==== test/ptc_mgmt_host.sv ====
module ptc_mgmt_host import ptc_pkg::*; (
  input  wire logic clk,
  output logic      mdc,
  output logic      mdo,
  output logic      moe,
  input  wire logic mdi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    mdc = 1'b0;
    mdo = 1'b1;
    moe = 1'b0;
  end
  // two clocks low, two high: the fastest mdc the block must follow
  task automatic bitc(input logic b);
    @(negedge clk) mdc = 1'b0;
    mdo = b;
    moe = 1'b1;
    @(negedge clk);
    @(negedge clk) mdc = 1'b1;
    @(negedge clk);
  endtask
  task automatic sbit(output logic b);
    @(negedge clk) mdc = 1'b0;
    moe = 1'b0;
    @(negedge clk) b = mdi;
    mdc = 1'b1;
    @(negedge clk);
    @(negedge clk);
  endtask
  // q = {second turnaround bit, data}; refused reads see the pull-up
  task automatic frame(input logic [4:0] pa, input logic [4:0] ra,
                       input logic rd, input logic [15:0] wd,
                       output logic [16:0] q);
    logic [13:0] hdr;
    int          i;
    hdr = {2'b01, rd ? PTC_OP_READ : PTC_OP_WRITE, pa, ra};
    for (i = 0; i < 32; i++) bitc(1'b1);
    for (i = 13; i >= 0; i--) bitc(hdr[i]);
    q = 17'h00000;
    if (rd) begin
      sbit(q[16]);
      for (i = 16; i >= 0; i--) sbit(q[i]);
    end else begin
      bitc(1'b1);
      bitc(1'b0);
      for (i = 15; i >= 0; i--) bitc(wd[i]);
    end
    @(negedge clk) mdc = 1'b0;
    moe = 1'b0;
  endtask
endmodule

// ==== test/testbench.sv ====
module testbench import ptc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int LIMIT = 90000;
  logic        clk, rst, ce, mdc, mdo, moe, fa, sv, sb;
  logic        mdio_out, mdio_drive_n;
  logic [4:0]  evt;
  wire  [15:0] ctl;
  wire         mdio_w;
  int          miscompares, num_checks, cycles, i;
  logic [4:0]  offs [5] = '{PTC_REG_FALSE_CARRIER, PTC_REG_DISCONNECT,
    PTC_REG_PREMATURE_END, PTC_REG_SLOW_EOF_ERROR, PTC_REG_JABBER_DETECT};
  // released line floats high through the pull-up
  assign mdio_w = !mdio_drive_n ? mdio_out : (moe ? mdo : 1'b1);
  assign ctl[10] = 1'b0;
  ptc_mgmt_host host (.clk(clk), .mdc(mdc), .mdo(mdo), .moe(moe),
                      .mdi(mdio_w));
  ptc_regs uut (.clk(clk), .rst(rst), .ce(ce), .mdc(mdc), .mdio_in(mdio_w),
    .mdio_out(mdio_out), .mdio_drive_n(mdio_drive_n),
    .false_carrier_evt(evt[0]), .disconnect_evt(evt[1]),
    .premature_end_evt(evt[2]), .slow_eof_err_evt(evt[3]),
    .jabber_evt(evt[4]), .rx_frame_active(fa), .rx_symbol_valid(sv),
    .rx_symbol_bad(sb), .scrambler_bypass(ctl[15]), .coder_bypass(ctl[14]),
    .force_h_pattern(ctl[13]), .force_34_pattern(ctl[12]),
    .force_link_good(ctl[11]), .tx_crs_disable(ctl[9]),
    .dyn_powerdown_disable(ctl[8]), .an_loopback(ctl[7]),
    .line_driver_tristate(ctl[6]), .rx_filter_bypass(ctl[5]),
    .auto_polarity_disable(ctl[4]), .squelch_test_disable(ctl[3]),
    .extended_squelch(ctl[2]), .link_integrity_disable(ctl[1]),
    .jabber_disable(ctl[0]));
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] ra, input logic [15:0] e);
    logic [16:0] q;
    host.frame(PTC_PHY_ADDR_VALUE, ra, 1'b1, 16'h0000, q);
    chk(q, {1'b0, e});
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [16:0] q;
    host.frame(PTC_PHY_ADDR_VALUE, ra, 1'b0, d, q);
  endtask
  task automatic ev(input logic [4:0] m, input int n);
    repeat (n) begin
      @(negedge clk) evt = m;
      @(negedge clk) evt = 5'h00;
    end
  endtask
  task automatic sym(input logic bad);
    @(negedge clk) sv = 1'b1;
    sb = bad;
    @(negedge clk) sv = 1'b0;
  endtask
  task automatic conclude;
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    logic [16:0] q;
    rst = 1'b1;
    ce = 1'b1;
    evt = 5'h00;
    fa = 1'b0;
    sv = 1'b0;
    sb = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rd(PTC_REG_SPECIAL_CONTROL, PTC_SPECIAL_CONTROL_RST);
    for (i = 0; i < 5; i++) rd(offs[i], 16'h0000);
    for (i = 0; i < 16; i++) begin
      wr(PTC_REG_SPECIAL_CONTROL, 16'h0001 << i);
      rd(PTC_REG_SPECIAL_CONTROL, 16'h0001 << i);
      chk({1'b0, ctl}, {1'b0, (16'h0001 << i) & 16'hFBFF});
    end
    wr(PTC_REG_SPECIAL_CONTROL, 16'hFFFF);
    rd(PTC_REG_SPECIAL_CONTROL, 16'hFFFF);
    chk({1'b0, ctl}, 17'h0FBFF);
    // a mid-run reset must drop every control bit again
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    chk({1'b0, ctl}, 17'h00000);
    rd(PTC_REG_SPECIAL_CONTROL, PTC_SPECIAL_CONTROL_RST);
    wr(PTC_REG_PHY_ADDRESS, 16'hFFFF);
    rd(PTC_REG_PHY_ADDRESS, 16'h0001);
    wr(PTC_REG_EQUALIZER, 16'hA5C3);
    rd(PTC_REG_EQUALIZER, 16'hA5C3);
    host.frame(5'h02, PTC_REG_PHY_ADDRESS, 1'b1, 16'h0000, q);
    chk(q, 17'h1FFFF);
    host.frame(PTC_PHY_ADDR_VALUE, 5'h05, 1'b1, 16'h0000, q);
    chk(q, 17'h1FFFF);
    for (i = 0; i < 5; i++) if (i != 2) ev(5'h01 << i, i + 2);
    for (i = 0; i < 5; i++) begin
      if (i != 2) begin
        rd(offs[i], 16'(i + 2));
        rd(offs[i], 16'h0000);
      end
    end
    @(negedge clk) ce = 1'b0;
    ev(5'h10, 2);
    ce = 1'b1;
    rd(PTC_REG_JABBER_DETECT, 16'h0000);
    // one event per high cycle, so a held level reaches the ceiling fast
    @(negedge clk) evt = 5'h02;
    repeat (65537) @(negedge clk);
    evt = 5'h00;
    rd(PTC_REG_DISCONNECT, 16'hFFFF);
    rd(PTC_REG_DISCONNECT, 16'h0000);
    @(negedge clk) fa = 1'b1;
    repeat (7) sym(1'b1);
    sym(1'b0);
    ev(5'h04, 1);
    @(negedge clk) fa = 1'b0;
    @(negedge clk) fa = 1'b1;
    sym(1'b1);
    @(negedge clk) fa = 1'b0;
    rd(PTC_REG_ERROR_FRAME, 16'h0002);
    rd(PTC_REG_SYMBOL_ERROR, 16'h0003);
    rd(PTC_REG_PREMATURE_END, 16'h0001);
    rd(PTC_REG_SYMBOL_ERROR, 16'h0000);
    // the 46th frame bit rises at negedge 183: event lands on the clear edge
    fork
      rd(PTC_REG_FALSE_CARRIER, 16'h0000);
      begin
        repeat (183) @(negedge clk);
        evt = 5'h01;
        @(negedge clk) evt = 5'h00;
      end
    join
    rd(PTC_REG_FALSE_CARRIER, 16'h0001);
    rd(PTC_REG_FALSE_CARRIER, 16'h0000);
    conclude();
  end
endmodule
bind ptc_regs ptc_regs_props u_props (.clk(clk), .rst(rst), .ce(ce),
  .mdc(mdc), .mdio_out(mdio_out), .mdio_drive_n(mdio_drive_n),
  .scrambler_bypass(scrambler_bypass),
  .line_driver_tristate(line_driver_tristate),
  .jabber_disable(jabber_disable));
